// >>> spr_pkg.sv
package spr_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 250;
   localparam int DEB_MS      = 2;    // least input level length
   localparam int SETTLE_MS   = 10;   // binary select settling window
   localparam int GAP_MS      = 50;   // pulse-count end gap
   localparam int ACK_MS      = 20;   // acknowledge pulse length
   localparam int ENC_MAX_KHZ = 18;   // highest encoder track rate
   localparam int DEB_CYC     = DEB_MS * CLK_MHZ * 1000;
   localparam int SETTLE_CYC  = SETTLE_MS * CLK_MHZ * 1000;
   localparam int GAP_CYC     = GAP_MS * CLK_MHZ * 1000;
   localparam int ACK_CYC     = ACK_MS * CLK_MHZ * 1000;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int SEL_W   = 5;   // binary select lines
   localparam int DET_N   = 8;   // detector results
   localparam int OUT_N   = 4;   // result outputs, output 0 is the ejector
   localparam int REF_W   = 16;  // taught reference word
   localparam int JOBS    = 32;
   localparam int TMR_W   = 24;
   localparam int DEB_W   = 20;
   localparam int ENC_W   = 16;
   localparam int ADDR_W  = 8;
   localparam int PIN_N   = 11;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_ENC    = 8'h08;
   localparam logic [7:0] ADR_REF    = 8'h0c;
   localparam logic [7:0] ADR_OUTCFG = 8'h10;  // four words, 0x10..0x1c

   // Control register fields
   localparam int CTRL_SEL_LSB  = 0;  // two bits, select mode
   localparam int CTRL_GATE     = 2;
   localparam int CTRL_REPEAT   = 3;
   localparam int CTRL_ACK      = 4;
   localparam int CTRL_TRIGMODE = 5;
   localparam int CTRL_PERM     = 6;
   localparam int CTRL_ENC      = 7;
   localparam int CTRL_CYCLIM   = 8;
   localparam logic [8:0] CTRL_RST = 9'h020;

   // Job select modes
   localparam logic [1:0] SEL_NONE  = 2'h0;
   localparam logic [1:0] SEL_BIN   = 2'h1;
   localparam logic [1:0] SEL_LEVEL = 2'h2;
   localparam logic [1:0] SEL_PULSE = 2'h3;

   localparam logic [4:0] JOB_RST = 5'h01;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SEL_W-1:0] bin;      // binary_select_lines, bit 0 = lsb
      logic             teach;
      logic             pulse;    // pulse-counted select
      logic             level;    // two-way select
      logic             repeat_en;
      logic             gate;
      logic             trig;
   } spr_pin_in_t;

   typedef struct packed {
      logic             ready;
      logic             valid;
      logic             ack;
      logic             illum;
      logic [OUT_N-1:0] res;
   } spr_pin_out_t;

   typedef struct packed {
      logic             single;   // one detector drives the output
      logic [2:0]       idx;
      logic             use_or;
      logic             inv_all;
      logic [DET_N-1:0] inv;
      logic [DET_N-1:0] en;
   } spr_outcfg_t;

   // Result of one output from detector results
   function automatic logic spr_eval(input spr_outcfg_t cfg, input logic [DET_N-1:0] det);
      logic [DET_N-1:0] d;
      logic             r;
      d = det ^ cfg.inv;
      if (cfg.single)
         r = d[cfg.idx];
      else if (cfg.use_or)
         r = |(d & cfg.en);
      else
         r = &(d | ~cfg.en);
      return r ^ cfg.inv_all;
   endfunction : spr_eval

endpackage : spr_pkg

// >>> spr_ref_mem.sv
`timescale 1ns/1ps
module spr_ref_mem
   import spr_pkg::*;
(
   // Clock
   input  logic             clk,
   // Write port
   input  logic             wr_en,
   input  logic [4:0]       wr_addr,
   input  logic [REF_W:0]   wr_data,
   // Read port
   input  logic [4:0]       rd_addr,
   output logic [REF_W:0]   rd_data
);

   // ----------------------------------------------------------------
   // Storage, no reset so kept words survive it
   // ----------------------------------------------------------------
   logic [REF_W:0] mem [JOBS];

   // Write
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   // Registered read
   always_ff @(posedge clk)
   begin
      rd_data <= mem[rd_addr];
   end

endmodule : spr_ref_mem

// >>> spr_io.sv
`timescale 1ns/1ps
// Contract
// - Two encoder tracks count up or down by phase, to 18 kHz.
// - Good input job change pulses acknowledge 20 ms; failure keeps it low.
// - Result outputs follow one detector or a logic combination.
// - Ready high only while a trigger can be taken; ready follows the idle state alone, high even with the gate low.
// - Valid high only while other outputs are valid.
// - Assigned gate passes triggers only while high.
// - Five binary lines pick jobs 1-31; any change drops ready.
// - Ready low until new job active; acknowledge precedes ready.
// - Two-way select taken only while ready; ready drops at change.
// - Two-way select high gives job 2, low job 1.
// - First pulse drops ready; pulses counted until a 50 ms gap.
// - Re-teach rise re-learns references of the current job.
// - Ready low throughout re-teaching.
// - Taught references volatile or kept over reset, by variant.
// - Two-way, pulse select and re-teach only in triggered mode.
// - Repeat gate keeps capturing until positive verdict or cycle limit.
// - Repeat gate also gates triggers.
// - Input levels act only after persisting 2 ms.
// - First binary line is the job number lsb.
module spr_io
   import spr_pkg::*;
#(
   parameter int DEB_CYCLES    = DEB_CYC,
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int GAP_CYCLES    = GAP_CYC,
   parameter int ACK_CYCLES    = ACK_CYC
)
(
   // Clock and reset
   input  logic               clk,
   input  logic               reset_n,
   // Register port
   input  logic [ADDR_W-1:0]  reg_addr,
   input  logic [31:0]        reg_wdata,
   input  logic               reg_wr,
   input  logic               reg_rd,
   output logic [31:0]        reg_rdata,
   // Process pins, active high
   input  spr_pin_in_t        pin_in,
   input  logic               enc_a,
   input  logic               enc_b,
   output spr_pin_out_t       pin_out,
   // Evaluation core
   output logic               trig_pulse,
   input  logic               result_done,
   input  logic [DET_N-1:0]   det_res,
   input  logic               cycle_limit_hit,
   output logic               job_load,
   output logic [4:0]         job_num,
   input  logic               job_done,
   input  logic               job_ok,
   output logic               teach_start,
   input  logic               teach_done,
   input  logic [REF_W-1:0]   teach_ref,
   output logic [REF_W-1:0]   ref_word,
   output logic               ref_valid
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE   = 7'b0000001,
      ST_CAPT   = 7'b0000010,
      ST_SETTLE = 7'b0000100,
      ST_GAP    = 7'b0001000,
      ST_LOAD   = 7'b0010000,
      ST_ACK    = 7'b0100000,
      ST_TEACH  = 7'b1000000
   } spr_state_t;

   spr_state_t        state_ff;
   logic [8:0]        ctrl_ff;
   spr_outcfg_t       outcfg_ff [OUT_N];
   logic [PIN_N-1:0]  s1_ff, s2_ff, s3_ff, clean_ff, deb_ff, prev_ff;
   logic [DEB_W-1:0]  deb_cnt_ff [PIN_N];
   logic [1:0]        es1_ff, es2_ff, es3_ff, eab_ff, eab_prev_ff;
   logic [ENC_W-1:0]  enc_cnt_ff;
   logic              enc_dir_ff;
   logic [TMR_W-1:0]  tmr_ff;
   logic [4:0]        cur_job_ff, pcnt_ff;
   logic [SEL_W-1:0]  bin_seen_ff;
   logic [JOBS-1:0]   temp_ok_ff;
   logic              valid_ff, ack_ff;
   logic [OUT_N-1:0]  res_ff;
   logic [REF_W:0]    mem_rd;
   spr_pin_in_t       pin;
   spr_pin_in_t       rise;
   logic [1:0]        sel_mode;
   logic              trig_mode, gate_ok, trig_ok, rep_go, verdict;

   assign pin       = spr_pin_in_t'(deb_ff);
   assign rise      = spr_pin_in_t'(deb_ff & ~prev_ff);
   assign sel_mode  = ctrl_ff[CTRL_SEL_LSB +: 2];
   assign trig_mode = ctrl_ff[CTRL_TRIGMODE];
   assign gate_ok   = (!ctrl_ff[CTRL_GATE] || pin.gate) && (!ctrl_ff[CTRL_REPEAT] || pin.repeat_en);
   assign trig_ok   = rise.trig && gate_ok && trig_mode;
   assign verdict   = spr_eval(outcfg_ff[0], det_res);
   assign rep_go    = ctrl_ff[CTRL_REPEAT] && pin.repeat_en && !verdict
                      && !(ctrl_ff[CTRL_CYCLIM] && cycle_limit_hit);

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   // Three-stage synchroniser, change taken when stages two and three agree
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_ff    <= '0;
         s2_ff    <= '0;
         s3_ff    <= '0;
         clean_ff <= '0;
      end
      else
      begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         clean_ff <= (s2_ff == s3_ff) ? s3_ff : clean_ff;
      end
   end

   // level must persist before it acts
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         deb_ff  <= '0;
         prev_ff <= '0;
         for (int i = 0; i < PIN_N; i++)
            deb_cnt_ff[i] <= '0;
      end
      else
      begin
         prev_ff <= deb_ff;
         for (int i = 0; i < PIN_N; i++)
         begin
            if (clean_ff[i] == deb_ff[i])
               deb_cnt_ff[i] <= '0;
            else if (deb_cnt_ff[i] >= DEB_W'(DEB_CYCLES - 1))
            begin
               deb_ff[i]     <= clean_ff[i];
               deb_cnt_ff[i] <= '0;
            end
            else
               deb_cnt_ff[i] <= deb_cnt_ff[i] + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Quadrature encoder
   // ----------------------------------------------------------------
   // direction-aware counting, synchroniser only for full rate
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         es1_ff      <= '0;
         es2_ff      <= '0;
         es3_ff      <= '0;
         eab_ff      <= '0;
         eab_prev_ff <= '0;
         enc_cnt_ff  <= '0;
         enc_dir_ff  <= 1'b0;
      end
      else
      begin
         es1_ff <= {enc_a, enc_b};
         es2_ff <= es1_ff;
         es3_ff <= es2_ff;
         for (int i = 0; i < 2; i++)
            eab_ff[i] <= (es2_ff[i] == es3_ff[i]) ? es3_ff[i] : eab_ff[i];
         eab_prev_ff <= eab_ff;
         if (ctrl_ff[CTRL_ENC] && (eab_ff != eab_prev_ff) && (eab_ff != ~eab_prev_ff))
         begin
            // Track A old against track B new gives the direction
            if (eab_prev_ff[1] ^ eab_ff[0])
            begin
               enc_cnt_ff <= enc_cnt_ff - 1'b1;
               enc_dir_ff <= 1'b1;
            end
            else
            begin
               enc_cnt_ff <= enc_cnt_ff + 1'b1;
               enc_dir_ff <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Trigger, job change and teach flow
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff    <= ST_IDLE;
         tmr_ff      <= '0;
         pcnt_ff     <= '0;
         bin_seen_ff <= '0;
         cur_job_ff  <= JOB_RST;
         job_num     <= JOB_RST;
         job_load    <= 1'b0;
         trig_pulse  <= 1'b0;
         teach_start <= 1'b0;
         ack_ff      <= 1'b0;
      end
      else
      begin
         job_load    <= 1'b0;
         trig_pulse  <= 1'b0;
         teach_start <= 1'b0;
         case (state_ff)
            ST_IDLE:
            begin
               tmr_ff <= '0;
               if (trig_ok)
               begin
                  trig_pulse <= 1'b1;
                  state_ff   <= ST_CAPT;
               end
               else if (sel_mode == SEL_BIN && pin.bin != bin_seen_ff)
                  state_ff <= ST_SETTLE;
               else if (sel_mode == SEL_LEVEL && trig_mode && pin.level != prev_ff[3])
               begin
                  job_num  <= pin.level ? 5'h02 : 5'h01;
                  job_load <= 1'b1;
                  state_ff <= ST_LOAD;
               end
               else if (sel_mode == SEL_PULSE && trig_mode && rise.pulse)
               begin
                  pcnt_ff  <= 5'h01;
                  state_ff <= ST_GAP;
               end
               else if (trig_mode && rise.teach)
               begin
                  teach_start <= 1'b1;
                  state_ff    <= ST_TEACH;
               end
            end
            ST_CAPT:
            begin
               if (result_done)
               begin
                  if (rep_go)
                     trig_pulse <= 1'b1;
                  else
                     state_ff <= ST_IDLE;
               end
            end
            ST_SETTLE:
            begin
               if (tmr_ff >= TMR_W'(SETTLE_CYCLES - 1))
               begin
                  tmr_ff      <= '0;
                  bin_seen_ff <= pin.bin;
                  // line 0 is the lsb, code zero fails
                  job_num     <= pin.bin;
                  job_load    <= (pin.bin != '0);
                  state_ff    <= (pin.bin != '0) ? ST_LOAD : ST_IDLE;
               end
               else
                  tmr_ff <= tmr_ff + 1'b1;
            end
            ST_GAP:
            begin
               // count pulses until the end gap
               if (rise.pulse)
               begin
                  tmr_ff  <= '0;
                  pcnt_ff <= (pcnt_ff == 5'h1f) ? pcnt_ff : pcnt_ff + 1'b1;
               end
               else if (pin.pulse)
                  tmr_ff <= '0;
               else if (tmr_ff >= TMR_W'(GAP_CYCLES - 1))
               begin
                  tmr_ff   <= '0;
                  job_num  <= pcnt_ff;
                  job_load <= 1'b1;
                  state_ff <= ST_LOAD;
               end
               else
                  tmr_ff <= tmr_ff + 1'b1;
            end
            ST_LOAD:
            begin
               if (job_done)
               begin
                  if (job_ok)
                     cur_job_ff <= job_num;
                  if (job_ok && ctrl_ff[CTRL_ACK])
                  begin
                     ack_ff   <= 1'b1;
                     state_ff <= ST_ACK;
                  end
                  else
                     state_ff <= ST_IDLE;
               end
            end
            ST_ACK:
            begin
               if (tmr_ff >= TMR_W'(ACK_CYCLES - 1))
               begin
                  tmr_ff   <= '0;
                  ack_ff   <= 1'b0;
                  state_ff <= ST_IDLE;
               end
               else
                  tmr_ff <= tmr_ff + 1'b1;
            end
            ST_TEACH:
            begin
               if (trig_ok)
                  trig_pulse <= 1'b1;
               if (teach_done)
                  state_ff <= ST_IDLE;
            end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Results and references
   // ----------------------------------------------------------------
   // outputs latched with valid
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         res_ff   <= '0;
         valid_ff <= 1'b0;
      end
      else if (result_done && (state_ff == ST_CAPT || state_ff == ST_TEACH))
      begin
         for (int i = 0; i < OUT_N; i++)
            res_ff[i] <= spr_eval(outcfg_ff[i], det_res);
         valid_ff <= 1'b1;
      end
      else if (trig_pulse || job_load)
         valid_ff <= 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         temp_ok_ff <= '0;
      else if (state_ff == ST_TEACH && teach_done)
         temp_ok_ff[cur_job_ff] <= 1'b1;
   end

   // kept words carry their own mark
   spr_ref_mem u_ref_mem (
      .clk     (clk),
      .wr_en   (state_ff == ST_TEACH && teach_done),
      .wr_addr (cur_job_ff),
      .wr_data ({ctrl_ff[CTRL_PERM], teach_ref}),
      .rd_addr (cur_job_ff),
      .rd_data (mem_rd)
   );

   assign ref_word  = mem_rd[REF_W-1:0];
   assign ref_valid = temp_ok_ff[cur_job_ff] || mem_rd[REF_W];

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   // all pins active high
   assign pin_out.ready = (state_ff == ST_IDLE);
   assign pin_out.valid = valid_ff;
   assign pin_out.ack   = ack_ff;
   assign pin_out.illum = (state_ff == ST_CAPT);
   assign pin_out.res   = res_ff;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Writes
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_ff <= CTRL_RST;
         for (int i = 0; i < OUT_N; i++)
            outcfg_ff[i] <= '0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADR_CTRL)
            ctrl_ff <= reg_wdata[8:0];
         for (int i = 0; i < OUT_N; i++)
            if (reg_addr == ADR_OUTCFG + 8'(4 * i))
               outcfg_ff[i] <= reg_wdata[$bits(spr_outcfg_t)-1:0];
      end
   end

   // Reads, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= '0;
      else
      begin
         reg_rdata <= '0;
         if (reg_rd)
         begin
            case (reg_addr)
               ADR_CTRL:   reg_rdata <= {23'h0, ctrl_ff};
               ADR_STATUS: reg_rdata <= {16'h0, state_ff, ref_valid, enc_dir_ff, valid_ff,
                                         pin_out.ready, cur_job_ff};
               ADR_ENC:    reg_rdata <= {16'h0, enc_cnt_ff};
               ADR_REF:    reg_rdata <= {15'h0, mem_rd};
               default:
               begin
                  for (int i = 0; i < OUT_N; i++)
                     if (reg_addr == ADR_OUTCFG + 8'(4 * i))
                        reg_rdata <= {10'h0, outcfg_ff[i]};
               end
            endcase
         end
      end
   end

endmodule : spr_io

// >>> spr_io_props.sv
`timescale 1ns/1ps
module spr_io_props
   import spr_pkg::*;
#(
   parameter int ACK_CYCLES = 10
)
(
   // Clock and reset
   input logic         clk,
   input logic         reset_n,
   // Watched ports
   input logic         reg_rd,
   input logic [31:0]  reg_rdata,
   input spr_pin_out_t pin_out,
   input logic         trig_pulse,
   input logic         result_done,
   input logic         job_load,
   input logic         job_done,
   input logic         job_ok,
   input logic         teach_start,
   input logic         teach_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [23:0] ack_cnt_ff;
   // Length of the acknowledge pulse
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         ack_cnt_ff <= 24'h0;
      else
         ack_cnt_ff <= pin_out.ack ? ack_cnt_ff + 24'h1 : 24'h0;
   AST_ACK_LEN: assert property ($fell(pin_out.ack) |-> ack_cnt_ff == ACK_CYCLES)
      else $error("ack length wrong");
   AST_ACK_FAIL: assert property (job_done && !job_ok |=> !pin_out.ack [*3])
      else $error("ack after failed change");
   AST_ACK_BUSY: assert property (pin_out.ack |-> !pin_out.ready)
      else $error("ready during ack");
   AST_ACK_READY: assert property ($fell(pin_out.ack) |-> ##[0:2] pin_out.ready)
      else $error("no ready after ack");
   AST_TRIG_BUSY: assert property (trig_pulse |-> !pin_out.ready && pin_out.illum)
      else $error("capture outputs wrong");
   AST_VALID_CLR: assert property (trig_pulse || job_load |=> !pin_out.valid)
      else $error("valid kept");
   AST_DONE_VALID: assert property (result_done |=> pin_out.valid)
      else $error("valid missing after result");
   AST_LOAD_BUSY: assert property (job_load |-> !pin_out.ready ##1 !pin_out.ready)
      else $error("ready during job load");
   AST_TEACH_BUSY: assert property (teach_start |=> !pin_out.ready until_with teach_done)
      else $error("ready during teach");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data without strobe");
   cover property (trig_pulse);
   cover property ($rose(pin_out.ack));
   cover property (teach_start);
endmodule : spr_io_props

bind spr_io spr_io_props #(.ACK_CYCLES(ACK_CYCLES)) spr_io_props_inst (.clk(clk), .reset_n(reset_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .trig_pulse(trig_pulse),
   .result_done(result_done), .job_load(job_load), .job_done(job_done), .job_ok(job_ok),
   .teach_start(teach_start), .teach_done(teach_done));

// >>> spr_core_model.sv
`timescale 1ns/1ps
module spr_core_model
   import spr_pkg::*;
(
   // Clock and reset
   input  logic             clk,
   input  logic             reset_n,
   // Requests
   input  logic             trig_pulse,
   input  logic             job_load,
   input  logic [4:0]       job_num,
   input  logic             teach_start,
   input  logic [DET_N-1:0] det_val,
   // Answers
   output logic             result_done,
   output logic [DET_N-1:0] det_res,
   output logic             job_done,
   output logic             job_ok,
   output logic             teach_done,
   output logic [REF_W-1:0] teach_ref
);
   logic [2:0] trg_ff, job_ff, tch_ff;
   // Answer each request three cycles later
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         {trg_ff, job_ff, tch_ff} <= 9'h0;
      else
         {trg_ff, job_ff, tch_ff} <= {trg_ff[1:0], trig_pulse, job_ff[1:0], job_load, tch_ff[1:0], teach_start};
   assign result_done = trg_ff[2];
   assign job_done    = job_ff[2];
   assign teach_done  = tch_ff[2];
   // Data good only with strobe; job 31 fails
   assign det_res     = result_done ? det_val : ~det_val;
   assign job_ok      = job_done ? (job_num != 5'h1f) : 1'b0;
   assign teach_ref   = teach_done ? 16'h5a3c : 16'ha5c3;
endmodule : spr_core_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench
   import spr_pkg::*;
;
   typedef struct {logic [4:0] code; logic [4:0] job; logic ack;} spr_row_t;
   logic clk, reset_n, reg_wr, reg_rd, enc_a, enc_b, trig_pulse, result_done, job_load, job_done;
   logic job_ok, teach_start, teach_done, ref_valid, lim, last_ack = 1'b0;
   logic [7:0] reg_addr, det_res, det_val;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [4:0] job_num, last_job;
   logic [15:0] teach_ref, ref_word;
   logic [1:0] qd [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   spr_pin_in_t pin_in;
   spr_pin_out_t pin_out;
   int error_cnt = 0, n_checks = 0, n_trig = 0, n_ack = 0, n_teach = 0, a0;
   spr_row_t rows [5] = '{'{5'h01, 5'h01, 1'b1}, '{5'h02, 5'h02, 1'b1}, '{5'h05, 5'h05, 1'b1},
                          '{5'h10, 5'h10, 1'b1}, '{5'h1f, 5'h10, 1'b0}};
   spr_io #(.DEB_CYCLES(4), .SETTLE_CYCLES(20), .GAP_CYCLES(40), .ACK_CYCLES(10)) spr_io_inst (.clk(clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .enc_a(enc_a), .enc_b(enc_b), .pin_out(pin_out),
      .trig_pulse(trig_pulse), .result_done(result_done), .det_res(det_res), .cycle_limit_hit(lim),
      .job_load(job_load), .job_num(job_num), .job_done(job_done), .job_ok(job_ok), .teach_start(teach_start),
      .teach_done(teach_done), .teach_ref(teach_ref), .ref_word(ref_word), .ref_valid(ref_valid));
   spr_core_model spr_core_model_inst (.clk(clk), .reset_n(reset_n), .trig_pulse(trig_pulse),
      .job_load(job_load), .job_num(job_num), .teach_start(teach_start), .det_val(det_val),
      .result_done(result_done), .det_res(det_res), .job_done(job_done), .job_ok(job_ok),
      .teach_done(teach_done), .teach_ref(teach_ref));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Event counters
   always @(posedge clk)
   begin
      if (job_load === 1'b1) last_job <= job_num;
      if (trig_pulse === 1'b1) n_trig <= n_trig + 1;
      if (teach_start === 1'b1) n_teach <= n_teach + 1;
      if (pin_out.ack === 1'b1 && last_ack === 1'b0) n_ack <= n_ack + 1;
      last_ack <= pin_out.ack;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic go(input int n);
      repeat (n) @(posedge clk);
      for (int i = 0; i < 400 && pin_out.ready !== 1'b1; i++) @(posedge clk);
      chk("ready", 32'h1, 32'(pin_out.ready));
   endtask : go
   task automatic trig();
      pin_in.trig <= 1'b1;
      repeat (10) @(posedge clk);
      pin_in.trig <= 1'b0;
      go(10);
   endtask : trig
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial
   begin
      pin_in = '0;
      {reg_wr, reg_rd, enc_a, enc_b, lim, reset_n} = 6'h0;
      {reg_addr, reg_wdata, det_val} = 48'h04;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(ADR_CTRL, rv);
      chk("ctrl", 32'h20, rv);
      rd(ADR_STATUS, rv);
      chk("status", 32'h21, {26'h0, rv[5:0]});
      rd(8'h40, rv);
      chk("unmapped", 32'h0, rv);
      $display("test reset done");
      // Binary job rows
      wr(ADR_CTRL, 32'h31);
      foreach (rows[i])
      begin
         a0 = n_ack;
         pin_in.bin <= rows[i].code;
         go(12);
         chk("job_num", 32'(rows[i].code), 32'(last_job));
         chk("ack", 32'(rows[i].ack), 32'(n_ack - a0));
         rd(ADR_STATUS, rv);
         chk("job", 32'(rows[i].job), 32'(rv[4:0]));
      end
      $display("test binary done");
      wr(ADR_CTRL, 32'h24);
      wr(ADR_OUTCFG, 32'h0028_0000);
      a0 = n_trig;
      trig();
      chk("gate_lo", 32'(a0), 32'(n_trig));
      pin_in.gate <= 1'b1;
      go(10);
      for (int k = 0; k < 2; k++)
      begin
         det_val <= k ? 8'hfb : 8'h04;
         trig();
         chk("res", 32'(det_val[2]), 32'(pin_out.res[0]));
         chk("valid", 32'h1, 32'(pin_out.valid));
      end
      chk("gate_hi", 32'(a0 + 2), 32'(n_trig));
      $display("test trigger done");
      wr(ADR_CTRL, 32'h22);
      pin_in.level <= 1'b1;
      go(12);
      chk("lvl_hi", 32'h2, 32'(last_job));
      pin_in.level <= 1'b0;
      go(12);
      chk("lvl_lo", 32'h1, 32'(last_job));
      // Select pulses
      wr(ADR_CTRL, 32'h23);
      repeat (3)
      begin
         pin_in.pulse <= 1'b1;
         repeat (10) @(posedge clk);
         pin_in.pulse <= 1'b0;
         repeat (10) @(posedge clk);
      end
      chk("pulse_busy", 32'h0, 32'(pin_out.ready));
      go(60);
      chk("pulses", 32'h3, 32'(last_job));
      wr(ADR_CTRL, 32'h60);
      a0 = n_teach;
      pin_in.teach <= 1'b1;
      go(12);
      pin_in.teach <= 1'b0;
      chk("teach", 32'(a0 + 1), 32'(n_teach));
      rd(ADR_REF, rv);
      chk("ref", 32'h0001_5a3c, rv);
      $display("test select and teach done");
      wr(ADR_CTRL, 32'ha0);
      for (int k = 1; k < 9; k++)
      begin
         {enc_a, enc_b} <= qd[k % 4];
         repeat (6) @(posedge clk);
      end
      rd(ADR_ENC, rv);
      chk("enc_up", 32'h8, rv);
      for (int k = 7; k >= 0; k--)
      begin
         {enc_a, enc_b} <= qd[k % 4];
         repeat (6) @(posedge clk);
      end
      rd(ADR_ENC, rv);
      chk("enc_dn", 32'h0, rv);
      $display("test encoder done");
      print_verdict();
   end
endmodule : testbench
